// File: src/post_seq.sv
// Power-on self-test sequencer with error log and AXI4-Lite register slave.
`timescale 1ns/1ps
`include "post_map.svh"

module post_seq #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   irq,
    output logic                   mem_check_req,
    output logic [2:0]             mem_check_sel,
    input  wire logic              mem_check_done,
    input  wire logic              mem_check_pass,
    output logic [11:0]            dac_a,
    output logic [11:0]            dac_b,
    output logic [7:0]             eight_bit_dac,
    output logic                   adc_start,
    input  wire logic              adc_done,
    input  wire logic [11:0]       monitor_adc,
    output logic                   secondary_preset_clear_o,
    output logic                   secondary_preset_clear_oe,
    input  wire logic              secondary_preset_clear_i,
    input  wire logic [3:0]        serial_err,
    input  wire logic [3:0]        panel_err,
    input  wire logic              cv_detect,
    input  wire logic              cc_detect,
    output logic                   voltage_loop_indicator,
    output logic                   current_loop_indicator,
    output logic                   unregulated_indicator,
    output logic                   self_test_fail_indicator
);

    localparam int SETTLE_CYC_I = (`POST_SETTLE_NS + `POST_CLK_NS - 1) / `POST_CLK_NS;
    localparam logic [11:0] SETTLE_CYC = 12'(SETTLE_CYC_I);

    if (ADDR_W < 5 || SETTLE_CYC_I < 1 || SETTLE_CYC_I > 4095)
    begin : g_bad_param
        $error("post_seq: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Step decoding.

    function automatic post_pkg::post_kind_t kind_of(input logic [3:0] s);
        if (s <= `POST_STEP_RAM)
            kind_of = post_pkg::K_MEM;
        else if (s <= 4'hB)
            kind_of = post_pkg::K_ADC;
        else
            kind_of = post_pkg::K_DIO;
    endfunction : kind_of

    function automatic post_pkg::post_code_t code_of(input logic [3:0] s);
        if (s < `POST_STEP_RAM)
            code_of = 8'(s) + 8'h01;
        else if (s == `POST_STEP_RAM)
            code_of = `POST_CODE_RAM;
        else if (s <= 4'h9)
            code_of = `POST_CODE_DAC12 + 8'(s - 4'h6);
        else if (s <= 4'hB)
            code_of = `POST_CODE_DAC8;
        else
            code_of = `POST_CODE_DIO;
    endfunction : code_of

    function automatic logic [4:0] bit_of(input logic [3:0] s);
        if (s <= 4'h9)
            bit_of = 5'(s);
        else if (s <= 4'hB)
            bit_of = 5'hA;
        else
            bit_of = 5'hB;
    endfunction : bit_of

    function automatic logic [11:0] expect_of(input logic [3:0] s);
        case (s)
            4'h6:    expect_of = `POST_ADC_ZERO_ZERO;
            4'h7:    expect_of = `POST_ADC_ONE_FS;
            4'h8:    expect_of = `POST_ADC_ONE_FS;
            4'h9:    expect_of = `POST_ADC_BOTH_FS;
            4'hA:    expect_of = 12'(`POST_DAC8_LOW);
            default: expect_of = 12'(`POST_DAC8_HIGH);
        endcase
    endfunction : expect_of

    function automatic logic in_window(input logic [11:0] v, input logic [11:0] e);
        logic [12:0] lo;
        logic [12:0] hi;
        lo = (e > `POST_ADC_TOL) ? 13'(e - `POST_ADC_TOL) : 13'h0000;
        hi = 13'(e) + 13'(`POST_ADC_TOL);
        in_window = (13'(v) >= lo) && (13'(v) <= hi);
    endfunction : in_window

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] st);
        for (int i = 0; i < 4; i++)
        begin
            merge[i*8 +: 8] = st[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////
    // Register storage and bus decode.

    post_pkg::post_state_t      state_q;
    logic [3:0]                 step_q;
    logic                       partial_q;
    logic                       por_q;
    logic [11:0]                cnt_q;
    logic                       any_fail_q;
    post_pkg::post_code_t       first_q;
    post_pkg::post_code_t       result_q;
    logic                       done_q;
    logic                       fail_ind_q;
    logic [`POST_LOG_W-1:0]     log_q;
    logic [2:0]                 irq_stat_q;
    logic [2:0]                 irq_mask_q;
    logic [11:0]                prog_a_q;
    logic [11:0]                prog_b_q;
    logic [7:0]                 prog8_q;
    logic                       aw_q;
    logic                       w_q;
    logic [ADDR_W-1:0]          awaddr_q;
    logic [31:0]                wdata_q;
    logic [3:0]                 wstrb_q;
    logic                       wr_en;
    logic                       rd_en;
    logic [7:0]                 wr_off;
    logic [7:0]                 rd_off;
    logic [31:0]                rd_word;
    logic                       rd_hit;
    logic                       wr_hit;
    logic [31:0]                wr_word;
    logic                       start_full;
    logic                       start_part;
    logic                       chk_evt;
    logic                       chk_fail;
    logic [`POST_LOG_W-1:0]     comm_set;
    logic                       own_dac;

    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_en  = aw_q && w_q && !s_axi_bvalid;
    assign rd_en  = s_axi_arvalid && s_axi_arready;
    assign wr_off = 8'({awaddr_q[ADDR_W-1:2], 2'b00});
    assign rd_off = 8'({s_axi_araddr[ADDR_W-1:2], 2'b00});
    assign wr_word = merge({4'h0, prog_b_q, 4'h0, prog_a_q}, wdata_q, wstrb_q);

    always_comb
    begin
        rd_hit  = 1'b1;
        rd_word = 32'h00000000;
        case (rd_off)
            `POST_OFF_CTRL:      rd_word = 32'h00000000;
            `POST_OFF_STATUS:    rd_word = {29'h0, done_q, fail_ind_q, state_q != post_pkg::S_IDLE};
            `POST_OFF_RESULT:    rd_word = {24'h0, result_q};
            `POST_OFF_ERR_LOG:   rd_word = {12'h0, log_q};
            `POST_OFF_IRQ_STAT:  rd_word = {29'h0, irq_stat_q};
            `POST_OFF_IRQ_MASK:  rd_word = {29'h0, irq_mask_q};
            `POST_OFF_PROG_DAC:  rd_word = {4'h0, prog_b_q, 4'h0, prog_a_q};
            `POST_OFF_PROG_DAC8: rd_word = {24'h0, prog8_q};
            default:             rd_hit  = 1'b0;
        endcase
    end

    always_comb
    begin
        case (wr_off)
            `POST_OFF_CTRL, `POST_OFF_STATUS, `POST_OFF_RESULT, `POST_OFF_ERR_LOG,
            `POST_OFF_IRQ_STAT, `POST_OFF_IRQ_MASK, `POST_OFF_PROG_DAC, `POST_OFF_PROG_DAC8:
                wr_hit = 1'b1;
            default:
                wr_hit = 1'b0;
        endcase
    end

    assign start_full = (wr_en && wr_off == `POST_OFF_CTRL && wstrb_q[0] && wdata_q[`POST_CTRL_FULL]) || por_q;
    assign start_part = wr_en && wr_off == `POST_OFF_CTRL && wstrb_q[0] && wdata_q[`POST_CTRL_PART];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            awaddr_q     <= '0;
            wdata_q      <= 32'h00000000;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_q     <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_en)
            begin
                aw_q         <= 1'b0;
                w_q          <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'b00;
        end
        else if (rd_en)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_mask_q <= `POST_RST_MASK;
            prog_a_q   <= `POST_RST_PROG_DAC;
            prog_b_q   <= `POST_RST_PROG_DAC;
            prog8_q    <= `POST_RST_DAC8;
        end
        else if (wr_en)
        begin
            if (wr_off == `POST_OFF_IRQ_MASK && wstrb_q[0])
                irq_mask_q <= wdata_q[2:0];
            if (wr_off == `POST_OFF_PROG_DAC)
            begin
                prog_a_q <= wr_word[11:0];
                prog_b_q <= wr_word[27:16];
            end
            if (wr_off == `POST_OFF_PROG_DAC8 && wstrb_q[0])
                prog8_q <= wdata_q[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test sequencer.

    always_comb
    begin
        chk_evt  = 1'b0;
        chk_fail = 1'b0;
        case (state_q)
            post_pkg::S_MEM_WAIT:
            begin
                chk_evt  = mem_check_done;
                chk_fail = !mem_check_pass;
            end
            post_pkg::S_ADC_WAIT:
            begin
                chk_evt  = adc_done;
                chk_fail = !in_window(monitor_adc, expect_of(step_q));
            end
            post_pkg::S_SETTLE:
            begin
                chk_evt  = cnt_q == 12'h001 && kind_of(step_q) == post_pkg::K_DIO;
                chk_fail = secondary_preset_clear_i != step_q[0];
            end
            default:
            begin
                chk_evt  = 1'b0;
                chk_fail = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q    <= post_pkg::S_IDLE;
            step_q     <= 4'h0;
            partial_q  <= 1'b0;
            por_q      <= 1'b1;
            cnt_q      <= 12'h000;
            any_fail_q <= 1'b0;
            first_q    <= 8'h00;
            result_q   <= 8'h00;
            done_q     <= 1'b0;
        end
        else
        begin
            por_q <= 1'b0;
            if (chk_evt && chk_fail && !any_fail_q)
            begin
                any_fail_q <= 1'b1;
                first_q    <= code_of(step_q);
            end
            case (state_q)
                post_pkg::S_IDLE:
                begin
                    if (start_full || start_part)
                    begin
                        partial_q  <= !start_full;
                        step_q     <= 4'h0;
                        any_fail_q <= 1'b0;
                        first_q    <= 8'h00;
                        done_q     <= 1'b0;
                        state_q    <= post_pkg::S_MEM_REQ;
                    end
                end
                post_pkg::S_MEM_REQ:
                    state_q <= post_pkg::S_MEM_WAIT;
                post_pkg::S_SET:
                begin
                    cnt_q   <= SETTLE_CYC;
                    state_q <= post_pkg::S_SETTLE;
                end
                post_pkg::S_SETTLE:
                begin
                    cnt_q <= cnt_q - 12'h001;
                    if (cnt_q == 12'h001 && kind_of(step_q) == post_pkg::K_ADC)
                        state_q <= post_pkg::S_ADC_REQ;
                end
                post_pkg::S_ADC_REQ:
                    state_q <= post_pkg::S_ADC_WAIT;
                post_pkg::S_DONE:
                begin
                    result_q <= first_q;
                    done_q   <= 1'b1;
                    state_q  <= post_pkg::S_IDLE;
                end
                default:
                    state_q <= state_q;
            endcase
            if (chk_evt)
            begin
                if (step_q == `POST_STEP_LAST || (partial_q && step_q == `POST_STEP_RAM))
                    state_q <= post_pkg::S_DONE;
                else
                begin
                    step_q  <= step_q + 4'h1;
                    state_q <= (kind_of(step_q + 4'h1) == post_pkg::K_MEM) ? post_pkg::S_MEM_REQ : post_pkg::S_SET;
                end
            end
        end
    end

    assign mem_check_req = state_q == post_pkg::S_MEM_REQ;
    assign mem_check_sel = step_q[2:0];
    assign adc_start     = state_q == post_pkg::S_ADC_REQ;
    assign own_dac = !partial_q && kind_of(step_q) != post_pkg::K_MEM
                  && state_q != post_pkg::S_IDLE && state_q != post_pkg::S_DONE;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dac_a                     <= `POST_RST_PROG_DAC;
            dac_b                     <= `POST_RST_PROG_DAC;
            eight_bit_dac             <= `POST_RST_DAC8;
            secondary_preset_clear_o  <= 1'b1;
            secondary_preset_clear_oe <= 1'b0;
        end
        else
        begin
            dac_a         <= prog_a_q;
            dac_b         <= prog_b_q;
            eight_bit_dac <= prog8_q;
            secondary_preset_clear_oe <= 1'b1;
            secondary_preset_clear_o  <= 1'b1;
            if (own_dac && kind_of(step_q) == post_pkg::K_ADC)
            begin
                dac_a <= (step_q == 4'h7 || step_q == 4'h9) ? `POST_DAC_FS : 12'h000;
                dac_b <= (step_q == 4'h8 || step_q == 4'h9) ? `POST_DAC_FS : 12'h000;
                eight_bit_dac <= step_q == 4'hA ? `POST_DAC8_LOW : step_q == 4'hB ? `POST_DAC8_HIGH : 8'h00;
            end
            if (own_dac && kind_of(step_q) == post_pkg::K_DIO)
                secondary_preset_clear_o <= step_q[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error log, indicators and interrupt.

    assign comm_set = {panel_err[3], panel_err[2], panel_err[1], panel_err[0],
                       serial_err[3], serial_err[2], serial_err[1], serial_err[0], 12'h000};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            log_q      <= '0;
            fail_ind_q <= 1'b0;
            irq_stat_q <= 3'h0;
        end
        else
        begin
            if (wr_en && wr_off == `POST_OFF_ERR_LOG)
            begin
                log_q      <= '0;
                fail_ind_q <= 1'b0;
            end
            if (rd_en && rd_off == `POST_OFF_IRQ_STAT)
                irq_stat_q <= 3'h0;
            log_q <= ((wr_en && wr_off == `POST_OFF_ERR_LOG) ? '0 : log_q) | comm_set
                   | ((chk_evt && chk_fail) ? (`POST_LOG_W'(1) << bit_of(step_q)) : '0);
            if (chk_evt && chk_fail)
                fail_ind_q <= 1'b1;
            irq_stat_q <= ((rd_en && rd_off == `POST_OFF_IRQ_STAT) ? 3'h0 : irq_stat_q)
                        | {|comm_set, chk_evt && chk_fail, state_q == post_pkg::S_DONE};
        end
    end

    assign self_test_fail_indicator = fail_ind_q;
    assign irq = |(irq_stat_q & irq_mask_q);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            voltage_loop_indicator <= 1'b0;
            current_loop_indicator <= 1'b0;
            unregulated_indicator  <= 1'b0;
        end
        else
        begin
            voltage_loop_indicator <= cv_detect;
            current_loop_indicator <= cc_detect && !cv_detect;
            unregulated_indicator  <= !cv_detect && !cc_detect;
        end
    end

endmodule : post_seq

// File: src/post_map.svh
// Register offsets, field positions, reset values, codes and clock and settle times in ns of the self-test sequencer.
`ifndef POST_MAP_SVH
`define POST_MAP_SVH

`define POST_CLK_NS        10
`define POST_SETTLE_NS     2000

`define POST_OFF_CTRL      8'h00
`define POST_OFF_STATUS    8'h04
`define POST_OFF_RESULT    8'h08
`define POST_OFF_ERR_LOG   8'h0C
`define POST_OFF_IRQ_STAT  8'h10
`define POST_OFF_IRQ_MASK  8'h14
`define POST_OFF_PROG_DAC  8'h18
`define POST_OFF_PROG_DAC8 8'h1C

`define POST_CTRL_FULL     0
`define POST_CTRL_PART     1
`define POST_STAT_BUSY     0
`define POST_STAT_FAIL     1
`define POST_STAT_DONE     2
`define POST_IRQ_DONE      0
`define POST_IRQ_FAIL      1
`define POST_IRQ_COMM      2
`define POST_PROG_B_LSB    16

`define POST_RST_MASK      3'h0
`define POST_RST_PROG_DAC  12'h000
`define POST_RST_DAC8      8'h00

`define POST_STEP_RAM      4'h5
`define POST_STEP_LAST     4'hD
`define POST_DAC_FS        12'hFFF
`define POST_ADC_TOL       12'h007
`define POST_ADC_ZERO_ZERO 12'h085
`define POST_ADC_ONE_FS    12'h047
`define POST_ADC_BOTH_FS   12'h00A
`define POST_DAC8_LOW      8'h0A
`define POST_DAC8_HIGH     8'hF0

`define POST_CODE_RAM      8'h0A
`define POST_CODE_DAC12    8'h0B
`define POST_CODE_DAC8     8'h0F
`define POST_CODE_DIO      8'h50
`define POST_CODE_SER_BUF  8'hD5
`define POST_CODE_SER_FRM  8'hD8
`define POST_CODE_SER_PAR  8'hD9
`define POST_CODE_SER_UART 8'hDA
`define POST_CODE_PNL_UART 8'hDC
`define POST_CODE_PNL_FRM  8'hDD
`define POST_CODE_PNL_PAR  8'hDE
`define POST_CODE_PNL_BUF  8'hDF

`define POST_LOG_W         20
`define POST_LOG_SER_LSB   12
`define POST_LOG_PNL_LSB   16

`endif

// File: src/post_pkg.sv
// Types shared by the self-test sequencer.
package post_pkg;

    typedef enum logic [3:0] {
        S_IDLE,
        S_MEM_REQ,
        S_MEM_WAIT,
        S_SET,
        S_SETTLE,
        S_ADC_REQ,
        S_ADC_WAIT,
        S_DONE
    } post_state_t;

    typedef enum logic [1:0] {
        K_MEM,
        K_ADC,
        K_DIO
    } post_kind_t;

    typedef logic [7:0] post_code_t;

endpackage : post_pkg

// File: sim/post_partner.sv
// Behavioural model of the checksum engine, the monitor ADC loopback and the preset-clear readback.
`timescale 1ns/1ps
module post_partner (
    input  wire logic        aclk,
    input  wire logic        mem_check_req,
    input  wire logic [2:0]  mem_check_sel,
    output logic             mem_check_done = 1'b0,
    output logic             mem_check_pass = 1'b0,
    input  wire logic [11:0] dac_a,
    input  wire logic [11:0] dac_b,
    input  wire logic [7:0]  eight_bit_dac,
    input  wire logic        adc_start,
    output logic             adc_done = 1'b0,
    output logic [11:0]      monitor_adc = 12'h000,
    input  wire logic        secondary_preset_clear_o,
    input  wire logic        secondary_preset_clear_oe,
    output logic             secondary_preset_clear_i,
    input  wire logic [2:0]  bad_sel,
    input  wire logic [11:0] adc_off,
    input  wire logic        dio_flip
);
    logic [3:0] mem_wait = 4'h0;
    logic [1:0] adc_wait = 2'h0;
    // The line has a pull-up, so it reads high while nobody drives it.
    assign secondary_preset_clear_i = secondary_preset_clear_oe ? secondary_preset_clear_o ^ dio_flip : 1'b1;
    always @(posedge aclk)
    begin
        mem_check_done <= 1'b0;
        mem_check_pass <= ~mem_check_pass;
        adc_done <= 1'b0;
        monitor_adc <= ~monitor_adc;
        if (mem_check_req) mem_wait <= {1'b0, mem_check_sel} + 4'h2;
        else if (mem_wait != 4'h0) mem_wait <= mem_wait - 4'h1;
        if (mem_wait == 4'h1)
        begin
            mem_check_done <= 1'b1;
            mem_check_pass <= mem_check_sel != bad_sel;
        end
        if (adc_start) adc_wait <= 2'h3;
        else if (adc_wait != 2'h0) adc_wait <= adc_wait - 2'h1;
        if (adc_wait == 2'h1)
        begin
            adc_done <= 1'b1;
            monitor_adc <= adc_off + (eight_bit_dac != 8'h00 ? {4'h0, eight_bit_dac} : dac_a != dac_b ? 12'h047 :
                dac_a == 12'h000 ? 12'h085 : 12'h00A);
        end
    end
endmodule : post_partner

// File: sim/post_seq_assertions.sv
// Concurrent checks on the ports of the self-test sequencer.
`timescale 1ns/1ps
module post_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        mem_check_req,
    input wire logic [2:0]  mem_check_sel,
    input wire logic        mem_check_done,
    input wire logic        mem_check_pass,
    input wire logic        adc_start,
    input wire logic [11:0] dac_a,
    input wire logic [11:0] dac_b,
    input wire logic [7:0]  eight_bit_dac,
    input wire logic        secondary_preset_clear_o,
    input wire logic        cv_detect,
    input wire logic        cc_detect,
    input wire logic        voltage_loop_indicator,
    input wire logic        unregulated_indicator,
    input wire logic        self_test_fail_indicator,
    input wire logic        s_axi_bvalid
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0] quiet_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || $changed({dac_a, dac_b, eight_bit_dac})) quiet_q <= 8'h00;
        else if (quiet_q != 8'hFF) quiet_q <= quiet_q + 8'h01;
    end
    a_mem_req_pulse: assert property (mem_check_req |=> !mem_check_req) else $error("long check request");
    a_mem_sel_range: assert property (mem_check_req |-> mem_check_sel <= 3'h5) else $error("bad region");
    a_adc_pulse: assert property (adc_start |=> !adc_start) else $error("long ADC start");
    a_dac_settled: assert property (adc_start |-> quiet_q >= 8'hB4) else $error("ADC sampled early");
    a_preset_return: assert property (!secondary_preset_clear_o |-> ##[1:300] secondary_preset_clear_o)
        else $error("preset clear stuck low");
    a_mem_fail_lights: assert property (mem_check_done && !mem_check_pass |-> ##[1:3] self_test_fail_indicator)
        else $error("fail lamp not lit");
    a_fail_sticky: assert property ($past(aresetn) && $fell(self_test_fail_indicator) |-> $rose(s_axi_bvalid))
        else $error("fail lamp lost");
    a_loop_cv: assert property ($past(aresetn) |-> voltage_loop_indicator == $past(cv_detect))
        else $error("voltage lamp wrong");
    a_loop_unreg: assert property ($past(aresetn) |-> unregulated_indicator == !$past(cv_detect || cc_detect))
        else $error("unregulated lamp wrong");
    c_mem_fail: cover property (mem_check_done && !mem_check_pass);
    c_preset_low: cover property (!secondary_preset_clear_o);
    c_fail_clear: cover property ($fell(self_test_fail_indicator));
endmodule : post_chk
bind post_seq post_chk i_chk (.aclk, .aresetn, .mem_check_req, .mem_check_sel, .mem_check_done, .mem_check_pass,
    .adc_start, .dac_a, .dac_b, .eight_bit_dac, .secondary_preset_clear_o, .cv_detect, .cc_detect,
    .voltage_loop_indicator, .unregulated_indicator, .self_test_fail_indicator, .s_axi_bvalid);

// File: sim/tb.sv
// Self-checking bench for the self-test sequencer.
`timescale 1ns/1ps
module tb;
    logic aclk = 1'b0, aresetn = 1'b0, cv_detect = 1'b0, cc_detect = 1'b0, dio_flip = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, irq, adc_start;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, eight_bit_dac;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb = 4'hF, serial_err = 4'h0, panel_err = 4'h0;
    logic [11:0] adc_off = 12'h000, dac_a, dac_b, monitor_adc;
    logic [2:0] bad_sel = 3'h7, mem_check_sel;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mem_check_req, mem_check_done;
    logic mem_check_pass, adc_done, voltage_loop_indicator, current_loop_indicator, unregulated_indicator;
    logic self_test_fail_indicator, secondary_preset_clear_o, secondary_preset_clear_oe, secondary_preset_clear_i;
    int error_cnt = 0, checked = 0, cyc = 0;
    post_seq i_dut (.*);
    post_partner i_far (.*);
    always #5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (error_cnt == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        v = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(v, e);
    endtask : rdc
    task automatic run(input logic [31:0] c);
        wr(8'h0C, 32'h0);
        wr(8'h00, c);
        do rd(8'h04); while (v[0] || !v[2]);
    endtask : run
    task automatic t_partial();
        wr(8'h18, 32'h04560123);
        for (int i = 0; i < 6; i++)
        begin
            bad_sel <= 3'(i);
            run(32'h2);
            rdc(8'h08, i == 5 ? 32'hA : 32'(i + 1));
            rdc(8'h0C, 32'h1 << i);
        end
        bad_sel <= 3'h7;
        chk({8'h00, dac_b, dac_a}, 32'h00456123);
        chk(32'(self_test_fail_indicator), 32'h1);
        wr(8'h18, 32'h0FFF0000);
        @(posedge aclk);
        chk({8'h00, dac_b, dac_a}, 32'h00FFF000);
    endtask : t_partial
    task automatic t_full();
        adc_off <= 12'h007;
        dio_flip <= 1'b1;
        run(32'h1);
        rdc(8'h08, 32'h50);
        rdc(8'h0C, 32'h800);
        adc_off <= 12'h008;
        dio_flip <= 1'b0;
        run(32'h1);
        rdc(8'h08, 32'hB);
        rdc(8'h0C, 32'h7C0);
        adc_off <= 12'h000;
    endtask : t_full
    task automatic t_comm();
        wr(8'h0C, 32'h0);
        rdc(8'h10, 32'h3);
        serial_err <= 4'h5;
        panel_err <= 4'hA;
        @(posedge aclk);
        serial_err <= 4'h0;
        panel_err <= 4'h0;
        rdc(8'h0C, 32'h000A5000);
        chk(32'(irq), 32'h1);
        rdc(8'h10, 32'h4);
        chk(32'(irq), 32'h0);
        rdc(8'h20, 32'h0);
        chk(32'(rr), 32'h2);
    endtask : t_comm
    task automatic t_loop();
        for (int i = 0; i < 4; i++)
        begin
            {cv_detect, cc_detect} <= 2'(i);
            repeat (2) @(posedge aclk);
            chk({29'h0, voltage_loop_indicator, current_loop_indicator, unregulated_indicator},
                {29'h0, i[1], i == 1, i == 0});
        end
    endtask : t_loop
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        do rd(8'h04); while (v[0] || !v[2]);
        rdc(8'h08, 32'h0);
        chk(32'(irq), 32'h0);
        wr(8'h14, 32'h7);
        chk(32'(irq), 32'h1);
        t_partial();
        t_full();
        t_comm();
        t_loop();
        stop_test();
    end
endmodule : tb
